// >>> inc/tsrt_map.svh
// Constants for the two-stage reload timer: widths, reset values, timing.
// Assumes inclusion by bare name from design files and the package.
`ifndef TSRT_MAP_SVH
`define TSRT_MAP_SVH

// ---------------------------------------------------------------
// Field widths and positions
// ---------------------------------------------------------------
`define TSRT_PRE_W 12
`define TSRT_CNT_W 16
`define TSRT_PRE_HI_MSB 11
`define TSRT_PRE_HI_LSB 8
`define TSRT_PRE_LO_MSB 7
`define TSRT_PRE_LO_LSB 0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define TSRT_PRE_RST 12'h000
`define TSRT_CNT_RST 16'h0000
`define TSRT_DIV_RST 1'h0

// ---------------------------------------------------------------
// Timing: crystal and tick rate in kHz
// ---------------------------------------------------------------
`define TSRT_XTAL_KHZ 27120
`define TSRT_TICK_KHZ 13560
`define TSRT_DIV_RATIO (`TSRT_XTAL_KHZ / `TSRT_TICK_KHZ)

`endif

// >>> inc/tsrt_pkg.sv
// Types shared by the timer top and its prescaler stage.
// Assumes tsrt_map.svh is reachable on the include path.
`include "tsrt_map.svh"

package tsrt_pkg;

  // ---------------------------------------------------------------
  // Host control bits for the timer
  // ---------------------------------------------------------------
  typedef struct packed {
    logic start_now;                     // Start pulse
    logic stop_now;                      // Stop pulse
    logic auto_start;                    // Protocol events start timer
    logic auto_restart;                  // Reload on zero instead of halt
    logic alt_prescale;                  // Even prescaler periods
    logic [`TSRT_PRE_HI_MSB-`TSRT_PRE_HI_LSB:0] pre_hi; // Upper reload
    logic [`TSRT_PRE_LO_MSB:0] pre_lo;   // Lower reload
    logic [`TSRT_CNT_W-1:0] cnt_reload;  // Counter reload
  } tsrt_ctrl_t;

  typedef enum logic [0:0] {
    TSRT_IDLE = 1'b0,
    TSRT_RUN = 1'b1
  } tsrt_state_t;

  // Prescaler state
  typedef struct packed {
    logic [`TSRT_PRE_W-1:0] cnt;         // Down count
    logic half;                          // Second pass of a period
    logic div;                           // Crystal-to-tick divider
  } tsrt_pre_t;

  // Top state
  typedef struct packed {
    tsrt_state_t st;
    logic [`TSRT_CNT_W-1:0] cnt;         // Live counter
    logic flag;                          // Expiry flag
  } tsrt_top_t;

endpackage : tsrt_pkg

// >>> rtl/tsrt_prescale.sv
// Prescaler stage: 12-bit reloadable down counter giving one expiry pulse.
// Assumes CLK is the 27.12 MHz crystal clock; it halves it to 13.56 MHz.
`include "tsrt_map.svh"

module tsrt_prescale (
  input wire logic clk,                          // Crystal clock
  input wire logic rst_n,                        // Async reset, low
  input wire logic run,                          // Stage is counting
  input wire logic alt,                          // Even period mode
  input wire logic [`TSRT_PRE_W-1:0] reload,     // Reload value
  output logic expire                            // One-cycle expiry
);

  tsrt_pkg::tsrt_pre_t s;
  tsrt_pkg::tsrt_pre_t next_s;
  logic tick;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    expire = 1'b0;
    tick = s.div;                                // Every second edge
    if (!run) begin
      next_s.cnt = reload;
      next_s.half = 1'b0;
      next_s.div = `TSRT_DIV_RST;
      tick = 1'b0;
    end else begin
      next_s.div = ~s.div;
      if (tick) begin
        // Reload+1 ticks in the first pass; the second pass makes the period
        // 2*reload+1 or 2*reload+2 ticks
        if (s.cnt != `TSRT_PRE_RST) begin
          next_s.cnt = s.cnt - 12'h001;
        end else if (!s.half) begin
          next_s.cnt = reload;
          next_s.half = 1'b1;
          if (!alt) begin
            next_s.cnt = reload - 12'h001;
            if (reload == `TSRT_PRE_RST) begin
              next_s.half = 1'b0;
              expire = 1'b1;
              next_s.cnt = reload;
            end
          end
        end else begin
          next_s.cnt = reload;
          next_s.half = 1'b0;
          expire = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Expiry only ever falls on a tick of a running stage
  expire_pulse_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    expire |-> run && s.div) else $error("expire off tick");

endmodule : tsrt_prescale

// >>> rtl/tsrt_timer.sv
// Two-stage reload timer: prescaler feeding a 16-bit reload down-counter.
// Assumes control bits arrive as synchronous ports, pulses one cycle wide.
//
// Function
// - Count at 13.56 MHz, half the 27.12 MHz crystal clock.
// - Prescaler expiries clock a separate reloadable main counter.
// - Prescaler reload 0..4095, upper four and lower eight bits.
// - Counter reload is a 16-bit value, 0 to 65535.
// - Live counter value is visible to the host.
// - Reaching zero sets expiry flag; enabled flag drives interrupt pin.
// - Host may set and clear the expiry flag.
// - At zero the counter halts or reloads, by configuration.
// - Running flag reports whether the timer counts.
// - Start-now starts, stop-now stops, immediately.
// - Auto-start bit lets protocol events start the timer.
// - The counter stage delays reload plus one prescaler expiries.
// - Default prescaler period is an odd number of ticks.
// - Alternative mode gives 2*reload+2 ticks, 4*reload+4 clocks, per period.
// - Expiry never alters any other internal operation.
// - Flag rises as the counter steps from one to zero.
`include "tsrt_map.svh"

module tsrt_timer (
  input wire logic CLK,                          // 27.12 MHz clock
  input wire logic RST_N,                        // Async reset, low
  input wire tsrt_pkg::tsrt_ctrl_t CTRL,         // Host control bits
  input wire logic PROTO_EVENT,                  // Protocol start pulse
  input wire logic FLAG_SET,                     // Host sets flag
  input wire logic FLAG_CLR,                     // Host clears flag
  input wire logic IRQ_EN,                       // Interrupt enable
  output logic [`TSRT_CNT_W-1:0] COUNT,          // Live counter value
  output logic RUNNING,                          // Timer running flag
  output logic EXPIRY_FLAG,                      // Timer expiry flag
  output logic IRQ                               // Interrupt request
);

  tsrt_pkg::tsrt_top_t s;
  tsrt_pkg::tsrt_top_t next_s;
  logic pre_exp;
  logic [`TSRT_PRE_W-1:0] pre_reload;
  logic zero_hit;
  logic run;

  // ---------------------------------------------------------------
  // Prescaler stage
  // ---------------------------------------------------------------
  assign run = (s.st == tsrt_pkg::TSRT_RUN);
  assign pre_reload = {CTRL.pre_hi, CTRL.pre_lo};

  tsrt_prescale u_pre (
    .clk(CLK),
    .rst_n(RST_N),
    .run(run),
    .alt(CTRL.alt_prescale),
    .reload(pre_reload),
    .expire(pre_exp)
  );

  // ---------------------------------------------------------------
  // Counter stage and flags
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    zero_hit = 1'b0;
    // Start loads the reload value; stop wins over a start in one cycle
    if (CTRL.start_now || (CTRL.auto_start && PROTO_EVENT)) begin
      next_s.st = tsrt_pkg::TSRT_RUN;
      next_s.cnt = CTRL.cnt_reload;
    end else if (run && pre_exp) begin
      if (s.cnt == 16'h0001 || s.cnt == `TSRT_CNT_RST) begin
        zero_hit = 1'b1;
        if (s.cnt == 16'h0001) begin
          next_s.cnt = `TSRT_CNT_RST;
        end else if (CTRL.auto_restart) begin
          next_s.cnt = CTRL.cnt_reload;
        end
        if (s.cnt == `TSRT_CNT_RST && !CTRL.auto_restart) begin
          next_s.st = tsrt_pkg::TSRT_IDLE;
        end
      end else begin
        next_s.cnt = s.cnt - 16'h0001;
      end
    end
    if (CTRL.stop_now) begin
      next_s.st = tsrt_pkg::TSRT_IDLE;
    end
    // Host clear loses to a same-cycle hardware set
    if (FLAG_CLR) begin
      next_s.flag = 1'b0;
    end
    if (FLAG_SET || (zero_hit && s.cnt == 16'h0001)) begin
      next_s.flag = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Expiry drives only the flag; nothing else in the chip is touched
  assign COUNT = s.cnt;
  assign RUNNING = run;
  assign EXPIRY_FLAG = s.flag;
  assign IRQ = s.flag && IRQ_EN;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // A start of either kind reloads the counter, so it is kept out
  flag_on_zero_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    run && pre_exp && s.cnt == 16'h0001 && !CTRL.start_now &&
    !(CTRL.auto_start && PROTO_EVENT) |=>
    EXPIRY_FLAG && COUNT == 16'h0000) else $error("no flag");
  irq_gate_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    IRQ == (EXPIRY_FLAG && IRQ_EN)) else $error("irq mismatch");
  flag_set_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    FLAG_SET |=> EXPIRY_FLAG) else $error("set lost");
  flag_clr_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    FLAG_CLR && !FLAG_SET && !(run && pre_exp) |=> !EXPIRY_FLAG)
    else $error("clear lost");
  start_now_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CTRL.start_now && !CTRL.stop_now |=>
    RUNNING && COUNT == $past(CTRL.cnt_reload)) else $error("no start");
  stop_now_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    CTRL.stop_now |=> !RUNNING) else $error("no stop");
  auto_start_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    PROTO_EVENT && !CTRL.auto_start && !CTRL.start_now && !RUNNING
    |=> !RUNNING) else $error("auto start off");
  halt_zero_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    run && pre_exp && s.cnt == 16'h0000 && !CTRL.auto_restart &&
    !CTRL.start_now && !(CTRL.auto_start && PROTO_EVENT) |=> !RUNNING)
    else $error("no halt");
  count_hold_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !pre_exp && !CTRL.start_now && !(CTRL.auto_start && PROTO_EVENT)
    |=> $stable(COUNT)) else $error("count moved");

endmodule : tsrt_timer

// >>> test/tb_top.sv
// Self-checking bench for the two-stage reload timer, driven at its ports.
// Assumes tsrt_pkg and tsrt_timer are compiled first; no partner model.
`include "tsrt_map.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  tsrt_pkg::tsrt_ctrl_t ctrl = '0;
  logic proto_event = 1'b0;
  logic flag_set = 1'b0;
  logic flag_clr = 1'b0;
  logic irq_en = 1'b0;
  logic [`TSRT_CNT_W-1:0] count;
  logic running;
  logic expiry_flag;
  logic irq;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;

  tsrt_timer dut (.CLK(clk), .RST_N(rst_n), .CTRL(ctrl),
    .PROTO_EVENT(proto_event), .FLAG_SET(flag_set), .FLAG_CLR(flag_clr),
    .IRQ_EN(irq_en), .COUNT(count), .RUNNING(running),
    .EXPIRY_FLAG(expiry_flag), .IRQ(irq));

  // Clock at 100 MHz
  initial begin
    forever #5 clk = ~clk;
  end

  // Hang guard: the longest scenario needs about 32800 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      error_cnt++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Counts cycles until the live counter moves
  task automatic wait_chg(output int n);
    logic [15:0] c;
    c = count;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (count === c && n < 20000);
  endtask : wait_chg

  // Counts cycles until the running flag drops
  task automatic wait_idle(output int n);
    n = 0;
    while (running !== 1'b0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_idle

  // One-cycle start pulse; the answer is sampled after it lands
  task automatic start_pulse();
    @(posedge clk) ctrl.start_now <= 1'b1;
    @(posedge clk) ctrl.start_now <= 1'b0;
    @(negedge clk);
  endtask : start_pulse

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    @(negedge clk);
    chk(count, 0);
    chk({running, expiry_flag, irq}, 0);
  endtask : t_reset

  // One-shot: period 4*2+2 clocks, four periods, flag then halt
  task automatic t_one_shot();
    int n;
    @(posedge clk) begin
      ctrl.pre_hi <= 4'h0;
      ctrl.pre_lo <= 8'h02;
      ctrl.cnt_reload <= 16'h0003;
      irq_en <= 1'b1;
    end
    start_pulse();
    chk({running, count}, {1'b1, 16'h0003});
    wait_chg(n);
    chk(n, 10);
    chk(count, 2);
    wait_chg(n);
    chk(n, 10);
    chk(count, 1);
    wait_chg(n);
    chk(n, 10);
    chk({count, expiry_flag, irq}, {16'h0, 2'h3});
    @(negedge clk);
    chk({expiry_flag, irq}, 2'h3);
    wait_idle(n);
    chk(n + 1, 10);
    repeat (12) @(negedge clk);
    chk({running, count}, 0);
  endtask : t_one_shot

  // Host set and clear of the flag, with the enable low
  task automatic t_flag();
    @(posedge clk) flag_clr <= 1'b1;
    @(posedge clk) flag_clr <= 1'b0;
    @(negedge clk);
    chk(expiry_flag, 0);
    @(posedge clk) begin
      flag_set <= 1'b1;
      irq_en <= 1'b0;
    end
    @(posedge clk) flag_set <= 1'b0;
    @(negedge clk);
    chk({expiry_flag, irq}, 2'h2);
    @(posedge clk) flag_clr <= 1'b1;
    @(posedge clk) flag_clr <= 1'b0;
    @(negedge clk);
    chk(expiry_flag, 0);
  endtask : t_flag

  // Even periods with reload at zero, then a stop with the count at zero
  task automatic t_alt_reload();
    int n;
    @(posedge clk) begin
      ctrl.pre_lo <= 8'h01;
      ctrl.cnt_reload <= 16'h0001;
      ctrl.alt_prescale <= 1'b1;
      ctrl.auto_restart <= 1'b1;
    end
    start_pulse();
    wait_chg(n);
    chk(n, 8);
    chk(count, 0);
    wait_chg(n);
    chk(n, 8);
    chk(count, 1);
    wait_chg(n);
    chk(n, 8);
    chk({count, running}, 17'h1);
    @(posedge clk) ctrl.stop_now <= 1'b1;
    @(posedge clk) ctrl.stop_now <= 1'b0;
    @(negedge clk);
    chk(running, 0);
    repeat (20) @(negedge clk);
    // Stopped at zero: count holds, flag from the expiry stays up
    chk({running, count, expiry_flag, irq}, 19'h2);
  endtask : t_alt_reload

  // Event start gated by the auto bit, at the largest prescaler value
  task automatic t_auto();
    int n;
    @(posedge clk) begin
      ctrl <= '{pre_hi: 4'hF, pre_lo: 8'hFF, cnt_reload: 16'h0001,
        default: '0};
      proto_event <= 1'b1;
    end
    @(posedge clk) proto_event <= 1'b0;
    repeat (3) @(negedge clk);
    chk(running, 0);
    @(posedge clk) ctrl.auto_start <= 1'b1;
    @(posedge clk) proto_event <= 1'b1;
    @(posedge clk) proto_event <= 1'b0;
    @(negedge clk);
    chk({running, count}, 17'h10001);
    wait_chg(n);
    chk(n, 16382);
    chk(count, 0);
    wait_idle(n);
    chk(n, 16382);
  endtask : t_auto

  // ---------------------------------------------------------------
  // Main sequence and verdict
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_one_shot();
    t_flag();
    t_alt_reload();
    t_auto();
    test_done();
  end
endmodule : tb_top
